//--- src/ccr_pkg.sv
package ccr_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_ONE_OFS   = 8'h05;
  localparam logic [7:0] CTRL_TWO_OFS   = 8'h06;
  localparam logic [7:0] CTRL_THREE_OFS = 8'h07;
  localparam logic [7:0] CTRL_FOUR_OFS  = 8'h08;

  // ****************************************************************
  // field positions inside the bytes
  // ****************************************************************
  localparam int TERM_BIT     = 7;
  localparam int STATUS_PIN_DISABLE_BIT = 6;
  localparam int WD_LSB       = 4;
  localparam int TIMER_EN_BIT = 3;
  localparam int FCT_LSB      = 1;
  localparam int SLOW_BIT     = 0;
  localparam int AUTO_DET_BIT = 6;
  localparam int TREG_LSB     = 4;
  localparam int CHG_EN_BIT   = 3;
  localparam int PRE_BIT      = 2;
  localparam int RECHG_LSB    = 0;
  localparam int LIGHT_LOAD_MODE_DISABLE_BIT  = 7;
  localparam int WATCHDOG_RESTART_BIT   = 6;
  localparam int TOPOFF_LSB   = 4;
  localparam int WARM_V_LSB   = 3;
  localparam int WARM_I_BIT   = 2;
  localparam int COOL_I_LSB   = 0;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] CTRL_ONE_RST   = 8'h9D;
  localparam logic [7:0] CTRL_TWO_RST   = 8'h7D;
  localparam logic [7:0] CTRL_THREE_RST = 8'h00;
  localparam logic [7:0] CTRL_FOUR_RST  = 8'h0D;
  // fixed pattern of the read-only bits of control three
  localparam logic [7:0] CTRL_THREE_RO  = 8'h02;

  // ****************************************************************
  // times and counts
  // ****************************************************************
  localparam int CLK_MHZ       = 100;
  localparam int TICKS_PER_SEC = CLK_MHZ * 1000000;
  localparam int WD_BASE_SEC   = 40;
  localparam int SEC_PER_HOUR  = 3600;
  localparam int FCT_5_HRS     = 5;
  localparam int FCT_8_HRS     = 8;
  localparam int FCT_12_HRS    = 12;
  localparam int FCT_20_HRS    = 20;

  // ****************************************************************
  // register fields carried to the rest of the charger
  // ****************************************************************
  typedef struct packed {
    logic       term_enable;
    logic       status_pin_disable;
    logic [1:0] watchdog_period;
    logic       safety_timer_enable;
    logic [1:0] fast_charge_timeout;
    logic       timer_slowdown_enable;
    logic       auto_source_detect_enable;
    logic [1:0] thermal_limit_threshold;
    logic       charge_enable;
    logic       precharge_exit_level;
    logic [1:0] recharge_offset;
    logic       light_load_mode_disable;
    logic [1:0] topoff_duration;
    logic [1:0] warm_zone_voltage;
    logic       warm_zone_current;
    logic [1:0] cool_zone_current;
  } ccr_cfg_s;

  // inputs from the analogue side and the charge sequencer
  typedef struct packed {
    logic input_power_regulation;
    logic thermal_regulation;
    logic charging_active;
    logic boost_request;
  } ccr_stat_s;

endpackage

//--- src/ccr_bank.sv
module ccr_bank #(
  parameter int TICKS_PER_SEC = ccr_pkg::TICKS_PER_SEC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              reg_reset_req,
  input  wire ccr_pkg::ccr_stat_s stat_in,
  output ccr_pkg::ccr_cfg_s      cfg,
  output logic                   watchdog_expired_flag,
  output logic                   safety_timer_expired,
  output logic                   boost_output_enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ccr_pkg::ccr_cfg_s cfg;
    logic [31:0]       sec_div;
    logic              sec_tick;
    logic [7:0]        wd_sec;
    logic              wd_flag;
    logic              half_phase;
    logic [16:0]       safety_sec;
    logic              safety_exp;
    logic              boost_en;
    logic [7:0]        rdata;
  } ccr_state_s;

  // the whole block state is one register, so reset and update stay in one place
  ccr_state_s state_r;
  ccr_state_s state_nxt;

  // ****************************************************************
  // register images and defaults
  // ****************************************************************
  // image of every field at its value after reset
  function automatic ccr_pkg::ccr_cfg_s defaults();
    ccr_pkg::ccr_cfg_s d;
    d.term_enable               = ccr_pkg::CTRL_ONE_RST[ccr_pkg::TERM_BIT];
    d.status_pin_disable        = ccr_pkg::CTRL_ONE_RST[ccr_pkg::STATUS_PIN_DISABLE_BIT];
    d.watchdog_period           = ccr_pkg::CTRL_ONE_RST[ccr_pkg::WD_LSB +: 2];
    d.safety_timer_enable       = ccr_pkg::CTRL_ONE_RST[ccr_pkg::TIMER_EN_BIT];
    d.fast_charge_timeout       = ccr_pkg::CTRL_ONE_RST[ccr_pkg::FCT_LSB +: 2];
    d.timer_slowdown_enable     = ccr_pkg::CTRL_ONE_RST[ccr_pkg::SLOW_BIT];
    d.auto_source_detect_enable = ccr_pkg::CTRL_TWO_RST[ccr_pkg::AUTO_DET_BIT];
    d.thermal_limit_threshold   = ccr_pkg::CTRL_TWO_RST[ccr_pkg::TREG_LSB +: 2];
    d.charge_enable             = ccr_pkg::CTRL_TWO_RST[ccr_pkg::CHG_EN_BIT];
    d.precharge_exit_level      = ccr_pkg::CTRL_TWO_RST[ccr_pkg::PRE_BIT];
    d.recharge_offset           = ccr_pkg::CTRL_TWO_RST[ccr_pkg::RECHG_LSB +: 2];
    d.light_load_mode_disable   = ccr_pkg::CTRL_THREE_RST[ccr_pkg::LIGHT_LOAD_MODE_DISABLE_BIT];
    d.topoff_duration           = ccr_pkg::CTRL_THREE_RST[ccr_pkg::TOPOFF_LSB +: 2];
    d.warm_zone_voltage         = ccr_pkg::CTRL_FOUR_RST[ccr_pkg::WARM_V_LSB +: 2];
    d.warm_zone_current         = ccr_pkg::CTRL_FOUR_RST[ccr_pkg::WARM_I_BIT];
    d.cool_zone_current         = ccr_pkg::CTRL_FOUR_RST[ccr_pkg::COOL_I_LSB +: 2];
    return d;
  endfunction

  // ****************************************************************
  // timer limits
  // ****************************************************************
  // watchdog limit in seconds: 40 shifted by the code minus one
  function automatic logic [7:0] wd_limit(input logic [1:0] code);
    logic [7:0] base;
    base = 8'(ccr_pkg::WD_BASE_SEC);
    unique case (code)
      2'b01:   wd_limit = base;
      2'b10:   wd_limit = 8'(base << 1);
      2'b11:   wd_limit = 8'(base << 2);
      default: wd_limit = 8'h00;
    endcase
  endfunction

  // safety timeout in seconds
  function automatic logic [16:0] fct_limit(input logic [1:0] code);
    int hrs;
    hrs = ccr_pkg::FCT_12_HRS;
    unique case (code)
      2'b00: hrs = ccr_pkg::FCT_5_HRS;
      2'b01: hrs = ccr_pkg::FCT_8_HRS;
      2'b10: hrs = ccr_pkg::FCT_12_HRS;
      2'b11: hrs = ccr_pkg::FCT_20_HRS;
    endcase
    fct_limit = 17'(hrs * ccr_pkg::SEC_PER_HOUR);
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // one process keeps write, expiry and reset priority in one place so
  // when two sources hit a field in the same cycle, the later one in the process wins
  always_comb
  begin
    ccr_pkg::ccr_cfg_s c;
    ccr_pkg::ccr_cfg_s d;
    logic              wd_restart;
    logic              wd_expire;
    logic              slow;
    logic              count_now;
    c          = state_r.cfg;
    d          = defaults();
    wd_restart = 1'b0;
    wd_expire  = 1'b0;
    slow       = 1'b0;
    count_now  = 1'b0;
    state_nxt  = state_r;

    // one-second enable pulse from the clock divider
    // the tick count is a parameter so that simulation can use short seconds
    state_nxt.sec_tick = 1'b0;
    if (state_r.sec_div == 32'(TICKS_PER_SEC - 1))
    begin
      state_nxt.sec_div  = 32'h0;
      state_nxt.sec_tick = 1'b1;
    end
    else
      state_nxt.sec_div = state_r.sec_div + 32'h1;

    // host writes; reserved bits are simply never stored
    if (reg_wr)
    begin
      unique case (reg_addr)
        // control one: termination, status pin, watchdog and safety timer
        ccr_pkg::CTRL_ONE_OFS:
        begin
          c.term_enable           = reg_wdata[ccr_pkg::TERM_BIT];
          c.status_pin_disable    = reg_wdata[ccr_pkg::STATUS_PIN_DISABLE_BIT];
          c.watchdog_period       = reg_wdata[ccr_pkg::WD_LSB +: 2];
          c.safety_timer_enable   = reg_wdata[ccr_pkg::TIMER_EN_BIT];
          c.fast_charge_timeout   = reg_wdata[ccr_pkg::FCT_LSB +: 2];
          c.timer_slowdown_enable = reg_wdata[ccr_pkg::SLOW_BIT];
        end

        // control two: detection, thermal limit, charge enable, thresholds
        ccr_pkg::CTRL_TWO_OFS:
        begin
          c.auto_source_detect_enable = reg_wdata[ccr_pkg::AUTO_DET_BIT];
          c.thermal_limit_threshold   = reg_wdata[ccr_pkg::TREG_LSB +: 2];
          c.charge_enable             = reg_wdata[ccr_pkg::CHG_EN_BIT];
          c.precharge_exit_level      = reg_wdata[ccr_pkg::PRE_BIT];
          c.recharge_offset           = reg_wdata[ccr_pkg::RECHG_LSB +: 2];
        end

        // control three: light-load mode, restart strobe, top-off duration
        ccr_pkg::CTRL_THREE_OFS:
        begin
          c.light_load_mode_disable = reg_wdata[ccr_pkg::LIGHT_LOAD_MODE_DISABLE_BIT];
          c.topoff_duration         = reg_wdata[ccr_pkg::TOPOFF_LSB +: 2];
          wd_restart                = reg_wdata[ccr_pkg::WATCHDOG_RESTART_BIT];
        end

        // control four: warm and cool zone settings
        ccr_pkg::CTRL_FOUR_OFS:
        begin
          c.warm_zone_voltage = reg_wdata[ccr_pkg::WARM_V_LSB +: 2];
          c.warm_zone_current = reg_wdata[ccr_pkg::WARM_I_BIT];
          c.cool_zone_current = reg_wdata[ccr_pkg::COOL_I_LSB +: 2];
        end
        default: ;
      endcase
    end

    // watchdog: counts whole seconds, restart bit is acted on and dropped
    // the divider runs free, so the first second after a restart may be short
    if (wd_restart || c.watchdog_period == 2'b00 || reg_reset_req)
      state_nxt.wd_sec = 8'h00;
    else if (state_r.sec_tick)
    begin
      if (state_r.wd_sec + 8'h01 >= wd_limit(c.watchdog_period))
      begin
        wd_expire        = 1'b1;
        state_nxt.wd_sec = 8'h00;
      end
      else
        state_nxt.wd_sec = state_r.wd_sec + 8'h01;
    end

    // expiry keeps recharge offset and light-load disable
    // expiry is applied after the host write, so it overrides a write in that cycle
    if (wd_expire)
    begin
      d.recharge_offset         = c.recharge_offset;
      d.light_load_mode_disable = c.light_load_mode_disable;
      c                         = d;
    end
    if (reg_reset_req)
      c = defaults();
    state_nxt.cfg = c;

    // expired flag: restart clears it, a new expiry in that cycle wins
    // a restart holds the count at zero, so in practice the two never meet
    if (wd_restart || reg_reset_req)
      state_nxt.wd_flag = 1'b0;
    if (wd_expire)
      state_nxt.wd_flag = 1'b1;

    // safety timer; slowed to half rate while any regulation loop acts
    // it stops at its limit and holds the expired level until disabled
    slow      = c.timer_slowdown_enable &&
                (stat_in.input_power_regulation || stat_in.thermal_regulation);
    count_now = state_r.sec_tick && (!slow || state_r.half_phase);
    if (state_r.sec_tick && slow)
      state_nxt.half_phase = !state_r.half_phase;
    if (!c.safety_timer_enable || !c.charge_enable || !stat_in.charging_active)
    begin
      state_nxt.safety_sec = 17'h0;
      state_nxt.safety_exp = 1'b0;
      state_nxt.half_phase = 1'b0;
    end
    else if (count_now && !state_r.safety_exp)
    begin
      if (state_r.safety_sec + 17'h1 >= fct_limit(c.fast_charge_timeout))
        state_nxt.safety_exp = 1'b1;
      state_nxt.safety_sec = state_r.safety_sec + 17'h1;
    end

    // charging wins over the boost output when both are asked for
    // registered from the new field value, so the enable changes in the same cycle as the field
    state_nxt.boost_en = stat_in.boost_request && !c.charge_enable;

    // read data, captured on the read strobe
    // a read sees a write of the same cycle, so read-after-write needs no gap
    if (reg_rd)
    begin
      unique case (reg_addr)
        // control one has no reserved bits
        ccr_pkg::CTRL_ONE_OFS:
          state_nxt.rdata = {c.term_enable, c.status_pin_disable, c.watchdog_period,
                             c.safety_timer_enable, c.fast_charge_timeout,
                             c.timer_slowdown_enable};
        // control two: top bit reserved
        ccr_pkg::CTRL_TWO_OFS:
          state_nxt.rdata = {1'b0, c.auto_source_detect_enable,
                             c.thermal_limit_threshold, c.charge_enable,
                             c.precharge_exit_level, c.recharge_offset};
        // control three: restart bit reads 0, bit 1 reads 1
        ccr_pkg::CTRL_THREE_OFS:
          state_nxt.rdata = {c.light_load_mode_disable, 1'b0,
                             c.topoff_duration, 4'h0} |
                            ccr_pkg::CTRL_THREE_RO;
        // control four: three reserved bits on top
        ccr_pkg::CTRL_FOUR_OFS:
          state_nxt.rdata = {3'h0, c.warm_zone_voltage,
                             c.warm_zone_current, c.cool_zone_current};
        default:
          state_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset loads field defaults; counters, flags and read data clear to zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r            <= '0;
      state_r.cfg        <= defaults();
    end
    else
      state_r <= state_nxt;
  end

  // outputs come straight from the state register
  // nothing is decoded on the way out, so no output can glitch
  assign cfg                   = state_r.cfg;
  assign reg_rdata             = state_r.rdata;
  assign watchdog_expired_flag = state_r.wd_flag;
  assign safety_timer_expired  = state_r.safety_exp;
  assign boost_output_enable   = state_r.boost_en;

endmodule

//--- dv/ccr_bank_assertions.sv
// ********
// port checker for the control bank
// ********
module ccr_bank_assertions #(
  parameter int TICKS_PER_SEC = 10
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_reset_req,
  input wire ccr_pkg::ccr_stat_s stat_in,
  input wire ccr_pkg::ccr_cfg_s  cfg,
  input wire logic               watchdog_expired_flag,
  input wire logic               safety_timer_expired,
  input wire logic               boost_output_enable
);
  timeunit 1ns;
  timeprecision 100ps;

  // every field at its default value
  localparam ccr_pkg::ccr_cfg_s DEF_CFG = {ccr_pkg::CTRL_ONE_RST,
    ccr_pkg::CTRL_TWO_RST[6:0], ccr_pkg::CTRL_THREE_RST[7],
    ccr_pkg::CTRL_THREE_RST[5:4], ccr_pkg::CTRL_FOUR_RST[4:0]};

  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  // fixed read bits of control three, restart bit included
  a_fixed_three:
    assert property (reg_rd && reg_addr == 8'h07 |=> (reg_rdata & 8'h4F) == 8'h02)
    else $error("control three fixed bits wrong");
  // a write to control one lands whole unless an expiry overrides it
  a_one_write:
    assert property (reg_wr && reg_addr == 8'h05 && !reg_reset_req |=>
      cfg[22:15] == $past(reg_wdata) || $rose(watchdog_expired_flag))
    else $error("control one write lost");
  a_boost_blocked:
    assert property (cfg.charge_enable |-> !boost_output_enable)
    else $error("boost while charging");
  // the enable is judged against the field value it was computed with
  a_boost_follows:
    assert property (stat_in.boost_request |=> boost_output_enable == !cfg.charge_enable)
    else $error("boost request ignored");
  // expiry restores fields in the flag cycle, except the two kept ones
  a_expiry_restores:
    assert property ($rose(watchdog_expired_flag) |->
      cfg[22:10] == DEF_CFG[22:10] && cfg[6:0] == DEF_CFG[6:0])
    else $error("expiry left fields unrestored");
  a_expiry_keeps:
    assert property ($rose(watchdog_expired_flag) && !$past(reg_wr) |->
      $stable(cfg.recharge_offset) && $stable(cfg.light_load_mode_disable))
    else $error("expiry changed kept fields");
  a_reg_reset:
    assert property (reg_reset_req |=> cfg == DEF_CFG && !watchdog_expired_flag)
    else $error("register reset incomplete");
  a_restart_clears:
    assert property (reg_wr && reg_addr == 8'h07 && reg_wdata[6] |=> !watchdog_expired_flag)
    else $error("restart left flag set");
  a_wd_disabled:
    assert property (cfg.watchdog_period == 2'b00 && !watchdog_expired_flag
      |=> !watchdog_expired_flag)
    else $error("disabled watchdog expired");

  c_expiry: cover property ($rose(watchdog_expired_flag));
  c_boost: cover property ($rose(boost_output_enable));
  c_safety: cover property ($rose(safety_timer_expired));
endmodule

bind ccr_bank ccr_bank_assertions #(.TICKS_PER_SEC(TICKS_PER_SEC)) i_ccr_bank_assertions (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_reset_req(reg_reset_req),
  .stat_in(stat_in), .cfg(cfg), .watchdog_expired_flag(watchdog_expired_flag),
  .safety_timer_expired(safety_timer_expired), .boost_output_enable(boost_output_enable)
);

//--- dv/ccr_host.sv
// ********
// host side of the register port
// ********
module ccr_host (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // one-cycle strobe; lines are inverted after use so no stale value is mistaken for data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    q         = reg_rdata;
  endtask
endmodule

//--- dv/ccr_bank_test.sv
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

module ccr_bank_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TPS = 1; // one-cycle seconds keep the slowed safety timeout near 36000 cycles

  logic               mclk;
  logic               rst;
  logic [7:0]         reg_addr;
  logic               reg_wr;
  logic [7:0]         reg_wdata;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic               reg_reset_req;
  ccr_pkg::ccr_stat_s stat;
  ccr_pkg::ccr_cfg_s  cfg;
  logic               watchdog_expired_flag;
  logic               safety_timer_expired;
  logic               boost_output_enable;
  logic [7:0]         q;
  logic [7:0]         sh [5:9] = '{8'h9D, 8'h7D, 8'h00, 8'h0D, 8'h00};
  int                 err_total;
  int                 num_checks;
  int                 cyc;
  int                 cyc_total;
  // write flag, address, data, expected read-back
  logic [24:0]        rows [12] = '{25'h0_05_00_9D, 25'h0_06_00_7D, 25'h0_07_00_02,
    25'h0_08_00_0D, 25'h1_05_77_77, 25'h1_06_FF_7F, 25'h1_07_FF_B2, 25'h1_08_FF_1F,
    25'h1_09_FF_00, 25'h1_08_E0_00, 25'h1_06_80_00, 25'h1_05_88_88};

  ccr_bank #(.TICKS_PER_SEC(TPS)) i_ccr_bank (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_reset_req(reg_reset_req), .stat_in(stat),
    .cfg(cfg), .watchdog_expired_flag(watchdog_expired_flag),
    .safety_timer_expired(safety_timer_expired), .boost_output_enable(boost_output_enable)
  );

  ccr_host i_ccr_host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd)
  );

  // field image of the four register bytes
  function automatic ccr_pkg::ccr_cfg_s img(logic [7:0] a, logic [7:0] b, logic [7:0] c,
                                            logic [7:0] d);
    return {a, b[6:0], c[7], c[5:4], d[4:0]};
  endfunction

  task automatic test_done();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // clock at 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard, counts from time zero and sits just above the whole run of about 54300 cycles
  always @(posedge mclk)
  begin
    cyc_total++;
    if (cyc_total == 60000)
    begin
      err_total++;
      test_done();
    end
  end

  initial
  begin
    rst = 1'b1;
    reg_reset_req = 1'b0;
    stat = '0;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    // table: reset values, masks, unmapped place; ends with watchdog off
    foreach (rows[i])
    begin
      if (rows[i][24])
      begin
        i_ccr_host.xfer(1'b1, rows[i][23:16], rows[i][15:8], q);
        sh[rows[i][23:16]] = rows[i][15:8];
      end
      i_ccr_host.xfer(1'b0, rows[i][23:16], 8'h00, q);
      `CHK(q, rows[i][7:0])
      `CHK(cfg, img(sh[5], sh[6], sh[7], sh[8]))
    end
    // boost only while charging is off
    stat.boost_request = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(boost_output_enable, 1'b1)
    i_ccr_host.xfer(1'b1, 8'h06, 8'h08, q);
    @(posedge mclk);
    #1;
    `CHK(boost_output_enable, 1'b0)
    // shortest safety timeout, no slow-down
    stat.charging_active = 1'b1;
    repeat (5 * 3600 * TPS - 100) @(posedge mclk);
    #1;
    `CHK(safety_timer_expired, 1'b0)
    repeat (200) @(posedge mclk);
    #1;
    `CHK(safety_timer_expired, 1'b1)
    // slowed safety timer: each regulation input alone halves the rate
    stat = '0;
    i_ccr_host.xfer(1'b1, 8'h05, 8'h89, q);
    stat.charging_active        = 1'b1;
    stat.input_power_regulation = 1'b1;
    repeat (5 * 3600 * TPS + 100) @(posedge mclk);
    #1;
    `CHK(safety_timer_expired, 1'b0)
    stat.input_power_regulation = 1'b0;
    stat.thermal_regulation     = 1'b1;
    repeat (5 * 3600 * TPS - 200) @(posedge mclk);
    #1;
    `CHK(safety_timer_expired, 1'b0)
    repeat (200) @(posedge mclk);
    #1;
    `CHK(safety_timer_expired, 1'b1)
    stat = '0;
    // restart at mid-count must push expiry out
    i_ccr_host.xfer(1'b1, 8'h05, 8'h9D, q);
    i_ccr_host.xfer(1'b1, 8'h06, 8'h03, q);
    repeat (10 * TPS) @(posedge mclk);
    i_ccr_host.xfer(1'b1, 8'h07, 8'hC0, q);
    repeat (40 * TPS - 10) @(posedge mclk);
    #1;
    `CHK(watchdog_expired_flag, 1'b0)
    cyc = 0;
    while (watchdog_expired_flag !== 1'b1 && cyc < 20)
    begin
      @(posedge mclk);
      cyc++;
    end
    #1;
    `CHK(watchdog_expired_flag, 1'b1)
    `CHK(cfg, img(8'h9D, 8'h7F, 8'h80, 8'h0D))
    i_ccr_host.xfer(1'b0, 8'h07, 8'h00, q);
    `CHK(q, 8'h82)
    // register reset clears kept fields and the flag
    reg_reset_req = 1'b1;
    @(posedge mclk);
    #1;
    reg_reset_req = 1'b0;
    `CHK(cfg, img(8'h9D, 8'h7D, 8'h00, 8'h0D))
    `CHK(watchdog_expired_flag, 1'b0)
    // asynchronous reset in mid-run restores fields and clears read data
    i_ccr_host.xfer(1'b1, 8'h08, 8'h00, q);
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK(cfg, img(8'h9D, 8'h7D, 8'h00, 8'h0D))
    `CHK(reg_rdata, 8'h00)
    test_done();
  end
endmodule
